// ### src/flow_device.sv
// How it works
// - Answer at address 0x40, 0x80 write, 0x81 read.
// - Work with bus rates up to 400 kHz.
// - Start and stop count only with SCL high.
// - Single bus master; other slaves may share.
// - After self-test, measure every 10 ms.
// - Update held value at each cycle end.
// - Command 0x1000 returns flow, high byte first.
// - Command 0x31AE returns the 32-bit identifier.
// - Identifier goes out most significant byte first.
// - Command 0x2000 is soft reset, no data.
// - Write command, then address-read, data plus checksum.
// - Flow returns two bytes, identifier four bytes.
// - CRC8 poly 0x131, init 0x00, MSB first.
// - Host discards first flow after initialisation.
`timescale 1ns/1ns
`default_nettype none
module flow_device
  import flow_pkg::*;
#(
  parameter int MEAS_CYCLES_P = MEAS_CYCLES,
  parameter int SELFTEST_CYCLES_P = SELFTEST_CYCLES,
  // Arbitrary identifier value.
  parameter logic [31:0] UNIQUE_ID = 32'h5A5A_0001
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic [15:0] flow_in,
  output logic [15:0] flow_held,
  output logic meas_done,
  output logic ready,
  output logic soft_reset_seen,
  i2c_link.device link
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_RACK, S_WAIT} dev_state_e;

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    dev_state_e st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic is_addr;
    logic rd;
    logic ncmd;
    logic [15:0] cmd;
    logic [2:0] nbytes;
    logic [2:0] bidx;
    logic [31:0] reply;
    logic [7:0] crc;
    logic acked;
    logic drive;
    logic [23:0] timer;
    logic testing;
    logic [15:0] flow;
    logic meas_done;
    logic srst;
  } dev_s;

  localparam logic [23:0] MEAS_LOAD = 24'(MEAS_CYCLES_P - 1);
  localparam logic [23:0] SELFTEST_LOAD = 24'(SELFTEST_CYCLES_P - 1);

  dev_s q;
  dev_s d;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic load;
    logic do_srst;
    logic [7:0] b;
    logic [15:0] full_cmd;
    scl_rise = q.scl_s && !q.scl_p;
    scl_fall = !q.scl_s && q.scl_p;
    start = q.scl_s && q.scl_p && q.sda_p && !q.sda_s;
    stop = q.scl_s && q.scl_p && !q.sda_p && q.sda_s;
    d = q;
    load = 1'b0;
    do_srst = 1'b0;
    b = 8'h00;
    full_cmd = {q.cmd[7:0], q.sh};
    d.scl_m = link.scl;
    d.scl_s = q.scl_m;
    d.scl_p = q.scl_s;
    d.sda_m = link.sda;
    d.sda_s = q.sda_m;
    d.sda_p = q.sda_s;
    d.meas_done = 1'b0;
    d.srst = 1'b0;

    if (q.timer == 24'h000000) begin
      if (!q.testing) begin
        d.flow = flow_in;
        d.meas_done = 1'b1;
      end
      d.testing = 1'b0;
      d.timer = MEAS_LOAD;
    end else begin
      d.timer = q.timer - 24'h000001;
    end

    case (q.st)
      S_IDLE: begin
      end
      S_RX: begin
        if (scl_rise) begin
          d.sh = {q.sh[6:0], q.sda_s};
          d.cnt = q.cnt + 4'h1;
        end
        if (scl_fall && q.cnt == BYTE_BITS) begin
          d.cnt = 4'h0;
          d.st = S_ACK;
          d.drive = 1'b1;
          if (q.is_addr) begin
            d.is_addr = 1'b0;
            d.rd = q.sh[0];
            if (q.sh[7:1] != DEV_ADDR || (q.sh[0] && q.nbytes == NO_BYTES)) begin
              d.st = S_WAIT;
              d.drive = 1'b0;
            end else if (q.sh[0]) begin
              d.crc = CRC_INIT;
              d.bidx = 3'h0;
              d.reply = (q.nbytes == ID_BYTES) ? UNIQUE_ID : {q.flow, 16'h0000};
            end
          end else begin
            d.cmd = full_cmd;
            d.ncmd = !q.ncmd;
            if (q.ncmd) begin
              case (full_cmd)
                CMD_FLOW: d.nbytes = FLOW_BYTES;
                CMD_ID: d.nbytes = ID_BYTES;
                CMD_RESET: begin
                  d.nbytes = NO_BYTES;
                  do_srst = 1'b1;
                end
                default: d.nbytes = NO_BYTES;
              endcase
            end
          end
        end
      end
      S_ACK: begin
        if (scl_fall) begin
          d.drive = 1'b0;
          d.st = S_RX;
          load = q.rd;
        end
      end
      S_TX: begin
        if (scl_rise) begin
          d.cnt = q.cnt + 4'h1;
        end
        if (scl_fall) begin
          if (q.cnt == BYTE_BITS) begin
            d.drive = 1'b0;
            d.cnt = 4'h0;
            d.st = S_RACK;
          end else begin
            d.sh = {q.sh[6:0], 1'b0};
            d.drive = !q.sh[6];
          end
        end
      end
      S_RACK: begin
        if (scl_rise) begin
          d.acked = !q.sda_s;
        end
        if (scl_fall) begin
          if (q.acked && q.bidx <= q.nbytes) begin
            load = 1'b1;
          end else begin
            d.st = S_WAIT;
          end
        end
      end
      S_WAIT: begin
      end
      default: d.st = S_IDLE;
    endcase

    if (load) begin
      if (q.bidx < q.nbytes) begin
        b = q.reply[31:24];
        d.reply = {q.reply[23:0], 8'h00};
        d.crc = crc8(q.crc, b);
      end else begin
        b = q.crc;
      end
      d.sh = b;
      d.drive = !b[7];
      d.bidx = q.bidx + 3'h1;
      d.cnt = 4'h0;
      d.st = S_TX;
    end

    if (do_srst) begin
      d.testing = 1'b1;
      d.timer = SELFTEST_LOAD;
      d.flow = 16'h0000;
      d.srst = 1'b1;
    end

    if (start) begin
      d.st = S_RX;
      d.cnt = 4'h0;
      d.is_addr = 1'b1;
      d.ncmd = 1'b0;
      d.drive = 1'b0;
    end else if (stop) begin
      d.st = S_IDLE;
      d.drive = 1'b0;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.scl_m <= 1'b1;
      q.scl_s <= 1'b1;
      q.scl_p <= 1'b1;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.sda_p <= 1'b1;
      q.timer <= SELFTEST_LOAD;
      q.testing <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign flow_held = q.flow;
  assign meas_done = q.meas_done;
  assign ready = !q.testing;
  assign soft_reset_seen = q.srst;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe = q.drive;

endmodule
`default_nettype wire

// ### src/flow_pkg.sv
`default_nettype none
package flow_pkg;

  // ****************************************
  // Bus and command constants
  // ****************************************
  localparam int CLK_HZ = 25000000;
  localparam logic [6:0] DEV_ADDR = 7'h40;
  localparam logic [7:0] ADDR_WR = 8'h80;
  localparam logic [7:0] ADDR_RD = 8'h81;
  localparam logic [15:0] CMD_FLOW = 16'h1000;
  localparam logic [15:0] CMD_ID = 16'h31AE;
  localparam logic [15:0] CMD_RESET = 16'h2000;
  localparam logic [2:0] FLOW_BYTES = 3'h2;
  localparam logic [2:0] ID_BYTES = 3'h4;
  localparam logic [2:0] NO_BYTES = 3'h0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam int BUS_MAX_HZ = 400000;
  localparam int BUS_DEF_HZ = 100000;

  // ****************************************
  // Checksum constants
  // ****************************************
  localparam logic [7:0] CRC_INIT = 8'h00;
  localparam logic [8:0] CRC_POLY = 9'h131;

  // ****************************************
  // Timing constants
  // ****************************************
  localparam int MEAS_PERIOD_MS = 10;
  localparam int MEAS_CYCLES = CLK_HZ / 1000 * MEAS_PERIOD_MS;
  localparam int SELFTEST_US = 100;
  localparam int SELFTEST_CYCLES = CLK_HZ / 1000000 * SELFTEST_US;
  localparam int GAP_QUARTERS = 8;

  // ****************************************
  // Shared functions
  // ****************************************
  // One byte of the CRC8, most significant bit first.
  function automatic logic [7:0] crc8(input logic [7:0] crc, input logic [7:0] b);
    logic [7:0] c;
    c = crc ^ b;
    for (int i = 0; i < 8; i++) begin
      c = c[7] ? ({c[6:0], 1'b0} ^ CRC_POLY[7:0]) : {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // Clock cycles in a quarter bit, rounded up so the rate never exceeds the request.
  function automatic int quarter(input int hz);
    return (CLK_HZ + 4 * hz - 1) / (4 * hz);
  endfunction

endpackage
`default_nettype wire

// ### src/i2c_link.sv
`timescale 1ns/1ns
`default_nettype none
interface i2c_link;
  logic scl_o;
  logic scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  wire logic scl;
  wire logic sda;

  // Open-drain lines with pull-ups.
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));

  modport device(input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host(input sda, output scl_o, output scl_oe, output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

// ### src/flow_host.sv
`timescale 1ns/1ns
`default_nettype none
module flow_host
  import flow_pkg::*;
#(
  parameter int BUS_HZ = BUS_DEF_HZ
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  input wire logic req,
  input wire logic [15:0] cmd,
  output logic busy,
  output logic done,
  output logic [31:0] data,
  output logic crc_ok,
  output logic nack,
  output logic flow_valid,
  i2c_link.host link
);

  // ****************************************
  // State
  // ****************************************
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_GAP} host_state_e;

  typedef struct packed {
    logic sda_m;
    logic sda_s;
    host_state_e st;
    logic [15:0] div;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [15:0] cmd;
    logic [2:0] n;
    logic rdp;
    logic [2:0] bidx;
    logic ackok;
    logic [7:0] gcnt;
    logic [7:0] crc;
    logic [31:0] data;
    logic crc_ok;
    logic nack;
    logic first;
    logic flow_valid;
    logic done;
    logic scl_oe;
    logic sda_oe;
  } host_s;

  localparam int QC = quarter(BUS_HZ > BUS_MAX_HZ ? BUS_MAX_HZ : BUS_HZ);
  localparam logic [15:0] QLOAD = 16'(QC - 1);
  localparam logic [7:0] GAP_LOAD = 8'(GAP_QUARTERS - 1);

  host_s q;
  host_s d;

  function automatic logic [7:0] tx_byte(input logic rdp, input logic [2:0] i,
                                         input logic [15:0] c);
    if (rdp) begin
      return ADDR_RD;
    end
    return (i == 3'h0) ? ADDR_WR : ((i == 3'h1) ? c[15:8] : c[7:0]);
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic tx;
    logic last;
    tx = !q.rdp || q.bidx == 3'h0;
    last = q.rdp && q.bidx == q.n + 3'h1;
    d = q;
    d.sda_m = link.sda;
    d.sda_s = q.sda_m;
    d.done = 1'b0;
    if (q.st == H_IDLE) begin
      if (req) begin
        d.cmd = cmd;
        d.n = (cmd == CMD_FLOW) ? FLOW_BYTES : ((cmd == CMD_ID) ? ID_BYTES : NO_BYTES);
        d.rdp = 1'b0;
        d.bidx = 3'h0;
        d.nack = 1'b0;
        d.crc_ok = 1'b0;
        d.ph = 2'h0;
        d.div = QLOAD;
        d.st = H_START;
      end
    end else if (q.div != 16'h0000) begin
      d.div = q.div - 16'h0001;
    end else begin
      d.div = QLOAD;
      d.ph = q.ph + 2'h1;
      case (q.st)
        H_START: begin
          if (q.ph == 2'h0) begin
            d.sda_oe = 1'b1;
          end else begin
            d.scl_oe = 1'b1;
            d.st = H_BIT;
            d.ph = 2'h0;
            d.bitn = 4'h0;
            d.sh = tx_byte(q.rdp, q.bidx, q.cmd);
          end
        end
        H_BIT: begin
          case (q.ph)
            2'h0: begin
              if (q.bitn < BYTE_BITS) begin
                d.sda_oe = tx && !q.sh[7];
              end else begin
                d.sda_oe = !tx && !last;
              end
            end
            2'h1: d.scl_oe = 1'b0;
            2'h2: begin
              if (q.bitn < BYTE_BITS) begin
                d.sh = {q.sh[6:0], q.sda_s};
              end else begin
                d.ackok = !q.sda_s;
              end
            end
            default: begin
              d.scl_oe = 1'b1;
              d.bitn = q.bitn + 4'h1;
              if (q.bitn == BYTE_BITS) begin
                d.bitn = 4'h0;
                d.sda_oe = 1'b0;
                if (!tx) begin
                  if (q.bidx <= q.n) begin
                    d.data = {q.data[23:0], q.sh};
                    d.crc = crc8(q.crc, q.sh);
                  end else begin
                    d.crc_ok = (q.sh == q.crc);
                  end
                end
                if (tx && !q.ackok) begin
                  d.nack = 1'b1;
                  d.st = H_STOP;
                end else if (last || (!q.rdp && q.bidx == 3'h2)) begin
                  d.st = H_STOP;
                end else begin
                  d.bidx = q.bidx + 3'h1;
                  d.sh = tx_byte(q.rdp, q.bidx + 3'h1, q.cmd);
                end
              end
            end
          endcase
        end
        H_STOP: begin
          case (q.ph)
            2'h0: d.sda_oe = 1'b1;
            2'h1: d.scl_oe = 1'b0;
            2'h2: d.sda_oe = 1'b0;
            default: begin
              if (!q.rdp && !q.nack && q.n != NO_BYTES) begin
                d.st = H_GAP;
                d.gcnt = GAP_LOAD;
                d.rdp = 1'b1;
                d.bidx = 3'h0;
                d.crc = CRC_INIT;
                d.data = 32'h0000_0000;
              end else begin
                d.st = H_IDLE;
                d.done = 1'b1;
                d.flow_valid = q.cmd == CMD_FLOW && q.crc_ok && !q.first;
                if (q.cmd == CMD_FLOW && q.crc_ok) begin
                  d.first = 1'b0;
                end
                if (q.cmd == CMD_RESET && !q.nack) begin
                  d.first = 1'b1;
                end
              end
            end
          endcase
        end
        H_GAP: begin
          if (q.gcnt == 8'h00) begin
            d.st = H_START;
            d.ph = 2'h0;
          end else begin
            d.gcnt = q.gcnt - 8'h01;
          end
        end
        default: d.st = H_IDLE;
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.sda_m <= 1'b1;
      q.sda_s <= 1'b1;
      q.first <= 1'b1;
    end else if (ce) begin
      q <= d;
    end
  end

  assign busy = q.st != H_IDLE;
  assign done = q.done;
  assign data = q.data;
  assign crc_ok = q.crc_ok;
  assign nack = q.nack;
  assign flow_valid = q.flow_valid;
  assign link.scl_o = 1'b0;
  assign link.scl_oe = q.scl_oe;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe = q.sda_oe;

endmodule
`default_nettype wire

// ### test/flow_sensor_i2c_readout_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module flow_sensor_i2c_readout_monitor
  import flow_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  // Minimum widths in 40 ns cycles: half bit 0.6 us, bit at 400 kHz, free bus 1 us.
  localparam int MIN_HALF = 15;
  localparam int MIN_BIT = 62;
  localparam int MIN_IDLE = 25;
  logic scl_q, sda_q;
  logic [7:0] hi_q, lo_q, bit_q, idle_q, nbit_q, sh_q;
  wire logic rise_w = scl && !scl_q;
  wire logic start_w = scl && scl_q && sda_q && !sda;
  wire logic stop_w = scl && scl_q && !sda_q && sda;

  always_ff @(posedge clk) begin
    if (reset) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      hi_q <= 8'hFF;
      lo_q <= 8'h00;
      bit_q <= 8'hFF;
      idle_q <= 8'hFF;
      nbit_q <= 8'h00;
      sh_q <= 8'h00;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      hi_q <= scl ? hi_q + {7'h00, hi_q != 8'hFF} : 8'h00;
      lo_q <= scl ? 8'h00 : lo_q + {7'h00, lo_q != 8'hFF};
      bit_q <= rise_w ? 8'h00 : bit_q + {7'h00, bit_q != 8'hFF};
      idle_q <= stop_w ? 8'h00 : idle_q + {7'h00, idle_q != 8'hFF};
      nbit_q <= start_w ? 8'h00 : nbit_q + {7'h00, rise_w && nbit_q != 8'hFF};
      sh_q <= rise_w ? {sh_q[6:0], sda} : sh_q;
    end
  end

  a_scl_high_width: assert property (@(posedge clk) disable iff (reset)
    (scl_q && !scl) |-> hi_q >= MIN_HALF) else $error("clock high phase too short");
  a_scl_low_width: assert property (@(posedge clk) disable iff (reset)
    (!scl_q && scl) |-> lo_q >= MIN_HALF) else $error("clock low phase too short");
  a_bit_rate_cap: assert property (@(posedge clk) disable iff (reset)
    rise_w |-> bit_q >= MIN_BIT) else $error("bit rate above limit");
  a_bus_free_time: assert property (@(posedge clk) disable iff (reset)
    start_w |-> idle_q >= MIN_IDLE) else $error("start too soon after stop");
  a_dev_edge_low: assert property (@(posedge clk) disable iff (reset)
    $changed(dev_sda_oe) |-> !scl) else $error("device data moved with clock high");
  a_stop_release: assert property (@(posedge clk) disable iff (reset)
    stop_w |-> (!dev_sda_oe) [*8]) else $error("device drives data after stop");
  a_addr_known: assert property (@(posedge clk) disable iff (reset)
    (rise_w && nbit_q == 8'h08) |-> (sh_q == ADDR_WR || sh_q == ADDR_RD))
    else $error("address byte not write or read form");
  a_write_ack: assert property (@(posedge clk) disable iff (reset)
    (rise_w && nbit_q == 8'h08 && sh_q == ADDR_WR) |-> !sda)
    else $error("write address not acknowledged");
  a_frame_bytes: assert property (@(posedge clk) disable iff (reset)
    stop_w |-> nbit_q % 8'h09 == 8'h01) else $error("frame not whole bytes");
  a_open_drain_low: assert property (@(posedge clk) disable iff (reset)
    !scl_o && !host_sda_o && !dev_sda_o) else $error("a pin driven high");
  a_start_by_host: assert property (@(posedge clk) disable iff (reset)
    start_w |-> (host_sda_oe && scl_oe == 1'b0 && !dev_sda_oe))
    else $error("start not made by the host");
endmodule
`default_nettype wire

// ### test/flow_sensor_i2c_readout_test.sv
`timescale 1ns/1ns
`default_nettype none
module flow_sensor_i2c_readout_test
  import flow_pkg::*;
;
  localparam int MEAS_P = 600;
  localparam int SELF_P = 50;
  // Arbitrary identifier value.
  localparam logic [31:0] ID_V = 32'hC3A5_0F96;
  logic clk, reset, req, busy, done, crc_ok, nack, flow_valid;
  logic meas_done, ready, soft_reset_seen, scl_d, sda_d;
  logic [15:0] cmd, flow_in, flow_held;
  logic [31:0] data;
  logic [7:0] sh;
  logic [7:0] bytes_q[$];
  int bad_count, n_tests, cyc, t_last, t_prev, srs_t, srs_n, nb, k;

  i2c_link link();
  flow_device #(.MEAS_CYCLES_P(MEAS_P), .SELFTEST_CYCLES_P(SELF_P), .UNIQUE_ID(ID_V))
    u_flow_device (.clk(clk), .reset(reset), .ce(1'b1), .flow_in(flow_in),
    .flow_held(flow_held), .meas_done(meas_done), .ready(ready),
    .soft_reset_seen(soft_reset_seen), .link(link.device));
  flow_host #(.BUS_HZ(BUS_MAX_HZ)) u_flow_host (.clk(clk), .reset(reset), .ce(1'b1),
    .req(req), .cmd(cmd), .busy(busy), .done(done), .data(data), .crc_ok(crc_ok),
    .nack(nack), .flow_valid(flow_valid), .link(link.host));
  flow_sensor_i2c_readout_monitor u_flow_sensor_i2c_readout_monitor (.clk(clk),
    .reset(reset), .scl_o(link.scl_o), .scl_oe(link.scl_oe), .host_sda_o(link.host_sda_o),
    .host_sda_oe(link.host_sda_oe), .dev_sda_o(link.dev_sda_o),
    .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************
  // Bus snooper and event timestamps
  // ****************************************
  always @(posedge clk) begin
    cyc = reset ? 0 : cyc + 1;
    if (meas_done === 1'b1) begin
      t_prev = t_last;
      t_last = cyc;
    end
    if (soft_reset_seen === 1'b1) begin
      srs_t = cyc;
      srs_n++;
    end
    if (link.scl && scl_d && sda_d && !link.sda) begin
      nb = 0;
      bytes_q = {};
    end else if (link.scl && !scl_d) begin
      if (nb % 9 == 8) bytes_q.push_back(sh);
      else sh = {sh[6:0], link.sda};
      nb++;
    end
    scl_d = link.scl;
    sda_d = link.sda;
  end

  function automatic logic [7:0] ref_crc(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    for (int i = 0; i < 8; i++)
      r = r[7] ? {r[6:0], 1'b0} ^ 8'h31 : {r[6:0], 1'b0};
    return r;
  endfunction

  function automatic logic win(input int d, input int e);
    return d >= e - 3 && d <= e + 3;
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run();
    $display("bad_count %0d n_tests %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wait_meas();
    int i;
    @(negedge clk);
    for (i = 0; i < 5000 && meas_done !== 1'b1; i++) @(negedge clk);
    check({31'h0, meas_done}, 32'h1);
    @(negedge clk);
  endtask

  task automatic run_cmd(input logic [15:0] c);
    int i;
    repeat (30) @(negedge clk);
    req = 1'b1;
    cmd = c;
    @(negedge clk);
    req = 1'b0;
    check({31'h0, busy}, 32'h1);
    for (i = 0; i < 20000 && done !== 1'b1; i++) @(negedge clk);
    check({31'h0, done}, 32'h1);
    check({31'h0, nack}, 32'h0);
    check({31'h0, busy}, 32'h0);
  endtask

  task automatic read_check(input logic [15:0] c, input int n, input logic [31:0] v,
                            input logic fv);
    logic [7:0] crc;
    int j;
    run_cmd(c);
    crc = 8'h00;
    check(n == 2 ? {16'h0, data[15:0]} : data, v);
    check({31'h0, crc_ok}, 32'h1);
    if (n == 2) check({31'h0, flow_valid}, {31'h0, fv});
    check(32'(bytes_q.size()), 32'(n + 2));
    check({24'h0, bytes_q[0]}, {24'h0, ADDR_RD});
    for (j = 0; j < n; j++) begin
      check({24'h0, bytes_q[j + 1]}, {24'h0, v[8 * (n - 1 - j) +: 8]});
      crc = ref_crc(crc, v[8 * (n - 1 - j) +: 8]);
    end
    check({24'h0, bytes_q[n + 1]}, {24'h0, crc});
  endtask

  initial begin
    #(40 * 80000);
    bad_count++;
    complete_run();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset = 1'b1;
    req = 1'b0;
    cmd = 16'h0000;
    flow_in = 16'h0000;
    scl_d = 1'b1;
    sda_d = 1'b1;
    void'($urandom(20));
    repeat (12) @(negedge clk);
    reset = 1'b0;
    flow_in = 16'($urandom);
    wait_meas();
    check({31'h0, ready}, 32'h1);
    check({31'h0, win(t_last, SELF_P + MEAS_P)}, 32'h1);
    wait_meas();
    check(32'(t_last - t_prev), 32'(MEAS_P));
    check({16'h0, flow_held}, {16'h0, flow_in});
    read_check(CMD_FLOW, 2, {16'h0, flow_in}, 1'b0);
    for (k = 0; k < 5; k++) begin
      flow_in = k == 0 ? 16'h0000 : k == 1 ? 16'hFFFF : 16'($urandom);
      wait_meas();
      read_check(CMD_FLOW, 2, {16'h0, flow_in}, 1'b1);
    end
    read_check(CMD_ID, 4, ID_V, 1'b0);
    run_cmd(16'($urandom) | 16'h0001);
    check({31'h0, flow_valid}, 32'h0);
    check(32'(bytes_q.size()), 32'h3);
    k = srs_n;
    run_cmd(CMD_RESET);
    check(32'(srs_n - k), 32'h1);
    check({16'h0, flow_held}, 32'h0);
    check(32'(bytes_q.size()), 32'h3);
    wait_meas();
    check({31'h0, win(t_last - srs_t, SELF_P + MEAS_P)}, 32'h1);
    read_check(CMD_FLOW, 2, {16'h0, flow_in}, 1'b0);
    read_check(CMD_FLOW, 2, {16'h0, flow_in}, 1'b1);
    complete_run();
  end
endmodule
`default_nettype wire
